// File: rtl/eid_page_ctrl.sv
`timescale 1ns/1ns
module eid_page_ctrl
	import eid_pkg::*;
#(
	parameter int WRITE_CYCLES = EID_WRITE_CYCLES,
	// Opcodes are parameters, their encodings are free
	parameter logic [7:0] ID_READ_OP = EID_OP_ID_READ,
	parameter logic [7:0] ID_WRITE_OP = EID_OP_ID_WRITE,
	parameter logic [7:0] LOCK_READ_OP = EID_OP_LOCK_READ,
	parameter logic [7:0] LOCK_OP = EID_OP_LOCK
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Serial pins
	input wire logic spi_cs_n_i,
	input wire logic spi_sck_i,
	input wire logic spi_mosi_i,
	input wire logic spi_wp_n_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	// Status control from the rest of the device
	input wire logic wel_set_i,
	input wire logic wel_clr_i,
	input wire logic protect_wr_i,
	input wire logic protect_sel_hi_i,
	input wire logic protect_sel_lo_i,
	input wire logic status_write_disable_i,
	input wire logic factory_init_i,
	// Status out
	output logic write_enable_latch_o,
	output logic write_busy_flag_o,
	output logic id_page_locked_o,
	output logic protect_sel_hi_o,
	output logic protect_sel_lo_o,
	output logic status_write_disable_o
);
	localparam int WCNT_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [WCNT_W-1:0] WCNT_LOAD = WCNT_W'(WRITE_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [EID_PIN_CNT-1:0] pins_w;
	logic [EID_PIN_CNT-1:0] sync1_reg;
	logic [EID_PIN_CNT-1:0] sync2_reg;
	logic [EID_PIN_CNT-1:0] sync3_reg;
	logic [EID_PIN_CNT-1:0] pin_reg;
	logic [EID_PIN_CNT-1:0] pin_prev_reg;
	logic cs_fall_w;
	logic cs_rise_w;
	logic sck_rise_w;
	logic sck_fall_w;
	logic mosi_w;
	logic wp_n_w;

	assign pins_w = {spi_wp_n_i, spi_mosi_i, spi_sck_i, spi_cs_n_i};

	genvar gi;
	generate
		for (gi = 0; gi < EID_PIN_CNT; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk_i)
			begin
				if (rst_i)
				begin
					sync1_reg[gi] <= EID_PIN_RST[gi];
					sync2_reg[gi] <= EID_PIN_RST[gi];
					sync3_reg[gi] <= EID_PIN_RST[gi];
					pin_reg[gi] <= EID_PIN_RST[gi];
					pin_prev_reg[gi] <= EID_PIN_RST[gi];
				end
				else
				begin
					sync1_reg[gi] <= pins_w[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					// Accept a change only when two stages agree
					if (sync2_reg[gi] == sync3_reg[gi])
						pin_reg[gi] <= sync3_reg[gi];
					pin_prev_reg[gi] <= pin_reg[gi];
				end
			end
		end
	endgenerate

	// Select resets low, so a fall needs a real high level first
	assign cs_fall_w = pin_prev_reg[0] && !pin_reg[0];
	assign cs_rise_w = !pin_prev_reg[0] && pin_reg[0];
	assign sck_rise_w = !pin_prev_reg[1] && pin_reg[1] && !pin_reg[0];
	assign sck_fall_w = pin_prev_reg[1] && !pin_reg[1] && !pin_reg[0];
	assign mosi_w = pin_reg[2];
	assign wp_n_w = pin_reg[3];

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	function automatic logic f_is_cmd(input logic [7:0] op);
		f_is_cmd = (op == ID_READ_OP) || (op == ID_WRITE_OP) ||
			(op == LOCK_READ_OP) || (op == LOCK_OP);
	endfunction : f_is_cmd

	function automatic eid_state_t f_addr_state(input logic [7:0] op, input logic a7);
		f_addr_state = ST_IGNORE;
		if (!a7 && op == ID_READ_OP)
			f_addr_state = ST_RD_ID;
		else if (a7 && op == LOCK_READ_OP)
			f_addr_state = ST_RD_LOCK;
		else if (!a7 && op == ID_WRITE_OP)
			f_addr_state = ST_WR_DATA;
		else if (a7 && op == LOCK_OP)
			f_addr_state = ST_LOCK_DATA;
	endfunction : f_addr_state

	////////////////////////////////////////////////////////////////////////////////
	// Command receiver

	eid_state_t st_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] rx_reg;
	logic [7:0] op_reg;
	logic [EID_PAGE_AW-1:0] addr_reg;
	logic got_data_reg;
	logic lock_ok_reg;
	logic [7:0] rx_byte_w;
	logic byte_done_w;
	logic write_busy_reg;
	logic write_enable_latch_reg;
	logic id_page_locked_reg;
	logic [1:0] protect_reg;
	logic status_write_disable_reg;

	assign rx_byte_w = {rx_reg[6:0], mosi_w};
	assign byte_done_w = sck_rise_w && (bit_cnt_reg == 3'h7);

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			st_reg <= ST_IDLE;
			bit_cnt_reg <= 3'h0;
			rx_reg <= 8'h00;
			op_reg <= 8'h00;
			addr_reg <= '0;
			got_data_reg <= 1'b0;
			lock_ok_reg <= 1'b0;
		end
		else if (pin_reg[0])
			st_reg <= ST_IDLE;
		else if (cs_fall_w && st_reg == ST_IDLE)
		begin
			st_reg <= ST_OPCODE;
			bit_cnt_reg <= 3'h0;
		end
		else if (sck_rise_w && st_reg != ST_IDLE)
		begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			rx_reg <= rx_byte_w;
			if (bit_cnt_reg == 3'h7)
			begin
				case (st_reg)
					ST_OPCODE:
					begin
						op_reg <= rx_byte_w;
						// Nothing of ours is taken while a cycle runs
						if (write_busy_reg || !f_is_cmd(rx_byte_w))
							st_reg <= ST_IGNORE;
						else
							st_reg <= ST_ADDR;
					end
					ST_ADDR:
					begin
						addr_reg <= rx_byte_w[EID_PAGE_AW-1:0];
						got_data_reg <= 1'b0;
						lock_ok_reg <= 1'b0;
						st_reg <= f_addr_state(op_reg, rx_byte_w[EID_A7_BIT]);
					end
					ST_WR_DATA:
					begin
						got_data_reg <= 1'b1;
						addr_reg <= addr_reg + 1'b1;
					end
					ST_LOCK_DATA:
					begin
						got_data_reg <= 1'b1;
						lock_ok_reg <= rx_byte_w[EID_LOCK_DATA_BIT];
					end
					default:
						st_reg <= st_reg;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write launch and self-timed cycle

	logic [WCNT_W-1:0] wcnt_reg;
	logic wkind_lock_reg;
	logic at_boundary_w;
	logic wr_allowed_w;
	logic start_page_w;
	logic start_lock_w;
	logic start_any_w;
	logic cycle_end_w;

	// Last byte fully taken and no bit of the next one yet
	assign at_boundary_w = got_data_reg && (bit_cnt_reg == 3'h0);
	assign wr_allowed_w = write_enable_latch_reg && wp_n_w && !write_busy_reg &&
		(protect_reg != EID_PROTECT_ALL);
	assign start_page_w = cs_rise_w && st_reg == ST_WR_DATA && at_boundary_w &&
		wr_allowed_w && !id_page_locked_reg;
	assign start_lock_w = cs_rise_w && st_reg == ST_LOCK_DATA && at_boundary_w &&
		wr_allowed_w && lock_ok_reg;
	assign start_any_w = start_page_w || start_lock_w;
	assign cycle_end_w = write_busy_reg && (wcnt_reg == '0);

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			write_busy_reg <= 1'b0;
			wcnt_reg <= '0;
			wkind_lock_reg <= 1'b0;
		end
		else if (start_any_w)
		begin
			write_busy_reg <= 1'b1;
			wcnt_reg <= WCNT_LOAD;
			wkind_lock_reg <= start_lock_w;
		end
		else if (cycle_end_w)
			write_busy_reg <= 1'b0;
		else if (write_busy_reg)
			wcnt_reg <= wcnt_reg - 1'b1;
	end

	// A set arriving with the end of a cycle wins over the clear
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			write_enable_latch_reg <= 1'b0;
		else if (wel_set_i)
			write_enable_latch_reg <= 1'b1;
		else if (wel_clr_i || cycle_end_w)
			write_enable_latch_reg <= 1'b0;
	end

	// Nonvolatile bits ignore rst_i; only the delivery load clears the lock bit, protect writes can also zero the others
	always_ff @(posedge ref_clk_i)
	begin
		if (factory_init_i)
		begin
			id_page_locked_reg <= 1'b0;
			protect_reg <= EID_PROTECT_INIT;
			status_write_disable_reg <= 1'b0;
		end
		else
		begin
			if (cycle_end_w && wkind_lock_reg)
				id_page_locked_reg <= 1'b1;
			if (protect_wr_i && !write_busy_reg)
			begin
				protect_reg <= {protect_sel_hi_i, protect_sel_lo_i};
				status_write_disable_reg <= status_write_disable_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Page storage and read prefetch

	logic [4:0] prod_addr_reg;
	logic prod_act_reg;
	logic pend_reg;
	logic prod_issue_w;
	logic rd_start_w;
	logic [7:0] mem_rd_data_w;
	logic fifo_in_ready_w;
	logic fifo_out_valid_w;
	logic fifo_out_ready_w;
	logic [7:0] fifo_out_data_w;
	logic tx_empty_reg;

	assign rd_start_w = byte_done_w && st_reg == ST_ADDR &&
		f_addr_state(op_reg, rx_byte_w[EID_A7_BIT]) == ST_RD_ID;
	// Stop at the page end instead of wrapping
	assign prod_issue_w = prod_act_reg && !pend_reg && !prod_addr_reg[4];

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || pin_reg[0])
		begin
			prod_act_reg <= 1'b0;
			pend_reg <= 1'b0;
			prod_addr_reg <= 5'h00;
		end
		else if (rd_start_w)
		begin
			prod_act_reg <= 1'b1;
			pend_reg <= 1'b0;
			prod_addr_reg <= {1'b0, rx_byte_w[EID_PAGE_AW-1:0]};
		end
		else if (prod_issue_w)
		begin
			pend_reg <= 1'b1;
			prod_addr_reg <= prod_addr_reg + 5'h01;
		end
		else if (pend_reg && fifo_in_ready_w)
			pend_reg <= 1'b0;
	end

	eid_page_mem #(
		.WIDTH(EID_BYTE_W),
		.DEPTH(EID_PAGE_BYTES),
		.AW(EID_PAGE_AW)
	) u_mem (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.stage_clr_i(byte_done_w && st_reg == ST_ADDR),
		.stage_we_i(byte_done_w && st_reg == ST_WR_DATA),
		.stage_addr_i(addr_reg),
		.stage_data_i(rx_byte_w),
		.commit_i(cycle_end_w && !wkind_lock_reg),
		.rd_en_i(prod_issue_w),
		.rd_addr_i(prod_addr_reg[EID_PAGE_AW-1:0]),
		.rd_data_o(mem_rd_data_w)
	);

	// Prefetch runs ahead of the shifter and stalls when the queue is full
	eid_fifo #(
		.WIDTH(EID_BYTE_W),
		.DEPTH(EID_FIFO_DEPTH)
	) u_fifo (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.flush_i(pin_reg[0] || rd_start_w),
		.in_valid_i(pend_reg),
		.in_ready_o(fifo_in_ready_w),
		.in_data_i(mem_rd_data_w),
		.out_valid_o(fifo_out_valid_w),
		.out_ready_i(fifo_out_ready_w),
		.out_data_o(fifo_out_data_w)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output shifter

	logic [7:0] tx_reg;
	logic [2:0] tx_cnt_reg;
	logic spi_miso_reg;
	logic spi_miso_oe_reg;
	logic rd_state_w;

	assign rd_state_w = (st_reg == ST_RD_ID) || (st_reg == ST_RD_LOCK);
	assign fifo_out_ready_w = (st_reg == ST_RD_ID) && tx_empty_reg && !sck_fall_w;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || pin_reg[0])
		begin
			spi_miso_oe_reg <= 1'b0;
			spi_miso_reg <= 1'b0;
			tx_reg <= 8'h00;
			tx_cnt_reg <= 3'h0;
			tx_empty_reg <= 1'b1;
		end
		else if (sck_fall_w && rd_state_w)
		begin
			spi_miso_oe_reg <= 1'b1;
			spi_miso_reg <= tx_reg[7];
			tx_reg <= {tx_reg[6:0], 1'b0};
			tx_cnt_reg <= tx_cnt_reg + 3'h1;
			if (tx_cnt_reg == 3'h7)
				tx_empty_reg <= 1'b1;
		end
		else if (st_reg == ST_RD_LOCK && tx_empty_reg)
		begin
			tx_reg <= {7'h00, id_page_locked_reg};
			tx_empty_reg <= 1'b0;
		end
		else if (fifo_out_ready_w && fifo_out_valid_w)
		begin
			tx_reg <= fifo_out_data_w;
			tx_empty_reg <= 1'b0;
		end
	end

	assign spi_miso_o = spi_miso_reg;
	assign spi_miso_oe_o = spi_miso_oe_reg;
	assign write_enable_latch_o = write_enable_latch_reg;
	assign write_busy_flag_o = write_busy_reg;
	assign id_page_locked_o = id_page_locked_reg;
	assign protect_sel_hi_o = protect_reg[1];
	assign protect_sel_lo_o = protect_reg[0];
	assign status_write_disable_o = status_write_disable_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_cycle_done;
		write_busy_reg && wcnt_reg == '0 && !wel_set_i;
	endsequence

	sequence s_launch;
		start_page_w || start_lock_w;
	endsequence

	a_busy_start: assert property (s_launch |=> write_busy_reg && wcnt_reg == WCNT_LOAD)
		else $error("write cycle not launched on select rise");
	a_busy_hold: assert property ($rose(write_busy_reg) |-> write_busy_reg [*8])
		else $error("busy flag dropped early");
	a_busy_end: assert property (s_cycle_done |=> !write_busy_reg && !write_enable_latch_reg)
		else $error("cycle end did not clear busy and latch");
	a_launch_guard: assert property (s_launch |-> write_enable_latch_reg &&
		protect_reg != EID_PROTECT_ALL && wp_n_w)
		else $error("write launched while protected");
	a_lock_boundary: assert property (start_lock_w |-> bit_cnt_reg == 3'h0 && lock_ok_reg)
		else $error("lock launched off a byte boundary");
	a_busy_ignore: assert property (st_reg == ST_OPCODE && byte_done_w && write_busy_reg
		&& !pin_reg[0] |=> st_reg == ST_IGNORE)
		else $error("command taken during write cycle");
	a_lock_repeat: assert property (st_reg == ST_RD_LOCK && tx_empty_reg && !sck_fall_w
		&& !pin_reg[0] |=> tx_reg == {7'h00, id_page_locked_reg})
		else $error("lock status byte wrong");
	a_read_release: assert property (cs_rise_w |=> !spi_miso_oe_reg)
		else $error("output still driven after deselect");
	a_select_first: assert property (st_reg == ST_IDLE && !cs_fall_w |=> st_reg == ST_IDLE)
		else $error("left idle without a select fall");
endmodule : eid_page_ctrl

// File: rtl/eid_pkg.sv
// Notes on behaviour
// - A separate 16-byte identification page, writable, and lockable forever as read-only.
// - Page read: opcode and address MSB first, A7 low, A3..A0 pick start byte.
// - During a page read the address steps after each byte, next byte follows.
// - Raising chip select ends a page read at any bit of the output.
// - A page read arriving during a write cycle is ignored.
// - A page write starts its timed cycle on the chip select rise.
// - Page write or lock is dropped when both protect bits are set or write protect is low.
// - Lock status byte carries the lock state in its least significant bit.
// - While selected, the lock status byte repeats without advancing.
// - A lock status read arriving during a write cycle is ignored.
// - Lock runs only if chip select rises exactly at a data byte boundary.
// - A valid lock starts a timed nonvolatile write cycle on chip select rise.
// - After power-up the device is deselected and needs a select fall first.
// - Power-up clears the write enable latch and the busy flag, no hold.
// - Protect bits are nonvolatile and survive resets.
// - Delivery state: protect and status write disable bits zero, page content undefined.
// - Write-type commands need the write enable latch set beforehand.
// - Busy flag is high for the whole write cycle, low when it ends.
package eid_pkg;
	localparam int EID_PAGE_BYTES = 16;
	localparam int EID_PAGE_AW = 4;
	localparam int EID_FIFO_DEPTH = 8;
	localparam int EID_BYTE_W = 8;
	localparam int EID_CLK_PERIOD_NS = 10;
	localparam int EID_WRITE_CYCLE_TIME_US = 4000;
	localparam int EID_WRITE_CYCLES = (EID_WRITE_CYCLE_TIME_US * 1000) / EID_CLK_PERIOD_NS;
	// Opcode defaults are arbitrary; read and lock pairs are told apart by A7
	localparam logic [7:0] EID_OP_ID_READ = 8'hb3;
	localparam logic [7:0] EID_OP_ID_WRITE = 8'hb2;
	localparam logic [7:0] EID_OP_LOCK_READ = 8'hb3;
	localparam logic [7:0] EID_OP_LOCK = 8'hb2;
	localparam int EID_A7_BIT = 7;
	localparam int EID_LOCK_DATA_BIT = 1;
	localparam logic [1:0] EID_PROTECT_ALL = 2'h3;
	localparam logic [1:0] EID_PROTECT_INIT = 2'h0;
	localparam int EID_PIN_CNT = 4;
	// Pin order: 0 chip select, 1 serial clock, 2 serial in, 3 write protect
	localparam logic [3:0] EID_PIN_RST = 4'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPCODE = 3'b001,
		ST_ADDR = 3'b010,
		ST_RD_ID = 3'b011,
		ST_RD_LOCK = 3'b100,
		ST_WR_DATA = 3'b101,
		ST_LOCK_DATA = 3'b110,
		ST_IGNORE = 3'b111
	} eid_state_t;
endpackage : eid_pkg

// File: rtl/eid_fifo.sv
`timescale 1ns/1ns
module eid_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready_o = (count_reg != (PW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || flush_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data_i;
	end
endmodule : eid_fifo

// File: rtl/eid_page_mem.sv
`timescale 1ns/1ns
module eid_page_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Staging of incoming write data
	input wire logic stage_clr_i,
	input wire logic stage_we_i,
	input wire logic [AW-1:0] stage_addr_i,
	input wire logic [WIDTH-1:0] stage_data_i,
	input wire logic commit_i,
	// Registered read port
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	// Page cells have no reset: their content is undefined until written
	logic [WIDTH-1:0] page_reg [DEPTH];
	logic [WIDTH-1:0] stage_reg [DEPTH];
	logic staged_reg [DEPTH];
	logic [WIDTH-1:0] rd_data_reg;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_cell
			always_ff @(posedge clk_i)
			begin
				if (rst_i || stage_clr_i)
					staged_reg[gi] <= 1'b0;
				else if (stage_we_i && stage_addr_i == AW'(gi))
				begin
					staged_reg[gi] <= 1'b1;
					stage_reg[gi] <= stage_data_i;
				end
				else if (commit_i)
					staged_reg[gi] <= 1'b0;
				if (commit_i && staged_reg[gi])
					page_reg[gi] <= stage_reg[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rd_en_i)
			rd_data_reg <= page_reg[rd_addr_i];
	end

	assign rd_data_o = rd_data_reg;
endmodule : eid_page_mem

// File: testbench/eid_spi_host.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module eid_spi_host (
	// Clock
	input wire logic clk_i,
	// Serial pins
	output logic cs_n_o,
	output logic sck_o,
	output logic mosi_o,
	input wire logic miso_i
);
	// Half a link period in system clocks, 160 ns per link bit
	localparam int HALF = 8;

	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick

	////////////////////////////////////////////////////////////////
	// A select fall opens every frame; sck stands low between frames
	task automatic start_frame();
		tick(1);
		cs_n_o = 1'b0;
		tick(HALF);
	endtask : start_frame

	// MSB first, data set while sck is low, miso taken just before the rise
	task automatic xfer_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			sck_o = 1'b0;
			mosi_o = tx[i];
			tick(HALF);
			rx[i] = miso_i;
			sck_o = 1'b1;
			tick(HALF);
		end
	endtask : xfer_bits

	// Select rises after the last rise and before any further one
	task automatic end_frame();
		sck_o = 1'b0;
		tick(HALF);
		cs_n_o = 1'b1;
		// Released data line must not keep looking like valid data
		mosi_o = ~mosi_o;
		tick(HALF);
	endtask : end_frame
endmodule : eid_spi_host

// File: testbench/tb_top.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module tb_top
	import eid_pkg::*;
;
	// Shortened write cycle, still long enough to span two read frames
	localparam int WC = 1200;
	localparam int LIMIT = 60000;
	logic ref_clk_i;
	logic rst_i;
	logic cs_n, sck, mosi, wp_n, miso, miso_oe;
	logic wel_set, wel_clr, prot_wr, prot_hi, prot_lo, swd_in, fac_init;
	logic write_enable_latch, busy, locked, prot_hi_q, prot_lo_q, swd_q;
	logic watch, oe_seen;
	logic [7:0] tx_buf [16];
	logic [7:0] rx_buf [16];
	int miscompares, compares;
	int cycles = 0;
	wire miso_line;

	// No pull on the data out line, so an undriven line reads as unknown
	assign miso_line = miso_oe ? miso : 1'bz;

	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	eid_spi_host u_host (
		.clk_i(ref_clk_i), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi), .miso_i(miso_line)
	);

	eid_page_ctrl #(
		.WRITE_CYCLES(WC)
	) u_eid_page_ctrl (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_mosi_i(mosi), .spi_wp_n_i(wp_n),
		.spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
		.wel_set_i(wel_set), .wel_clr_i(wel_clr), .protect_wr_i(prot_wr),
		.protect_sel_hi_i(prot_hi), .protect_sel_lo_i(prot_lo),
		.status_write_disable_i(swd_in), .factory_init_i(fac_init),
		.write_enable_latch_o(write_enable_latch), .write_busy_flag_o(busy), .id_page_locked_o(locked),
		.protect_sel_hi_o(prot_hi_q), .protect_sel_lo_o(prot_lo_q),
		.status_write_disable_o(swd_q)
	);

	always @(posedge ref_clk_i)
	begin
		cycles <= cycles + 1;
		if (watch && miso_oe === 1'b1)
			oe_seen <= 1'b1;
		if (cycles == LIMIT)
		begin
			miscompares = miscompares + 1;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	function automatic logic [7:0] pat(input int i);
		return 8'(i * 29) ^ 8'h5a;
	endfunction : pat

	task automatic clk_n(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : clk_n

	task automatic pulse_wel(input logic set);
		clk_n(1);
		wel_set = set;
		wel_clr = ~set;
		clk_n(1);
		wel_set = 1'b0;
		wel_clr = 1'b0;
	endtask : pulse_wel

	task automatic set_prot(input logic [1:0] p, input logic swd);
		clk_n(1);
		{prot_hi, prot_lo} = p;
		swd_in = swd;
		prot_wr = 1'b1;
		clk_n(1);
		prot_wr = 1'b0;
		clk_n(1);
	endtask : set_prot

	task automatic frame(input logic [7:0] op, input logic [7:0] addr, input int n,
		input int extra);
		logic [7:0] r;
		u_host.start_frame();
		u_host.xfer_bits(op, 8, r);
		u_host.xfer_bits(addr, 8, r);
		for (int i = 0; i < n; i++)
		begin
			u_host.xfer_bits(tx_buf[i], 8, r);
			rx_buf[i] = r;
		end
		if (extra > 0)
			u_host.xfer_bits(8'h00, extra, r);
		u_host.end_frame();
	endtask : frame

	// Busy was already up a few cycles when counting starts
	task automatic wait_done(input logic chk);
		int n;
		n = 0;
		while (busy === 1'b1 && n < 3000)
		begin
			clk_n(1);
			n++;
		end
		if (chk)
			check(8'(n >= WC - 12 && n <= WC), 8'h01, "busy length");
		clk_n(2);
		check(8'({busy, write_enable_latch}), 8'h00, "cycle end");
	endtask : wait_done

	////////////////////////////////////////////////////////////////
	task automatic t_power();
		check(8'({write_enable_latch, busy, miso_oe}), 8'h00, "power-up state");
		clk_n(1);
		fac_init = 1'b1;
		clk_n(1);
		fac_init = 1'b0;
		clk_n(1);
		check(8'({locked, prot_hi_q, prot_lo_q, swd_q}), 8'h00, "delivery");
		pulse_wel(1'b1);
		check(8'(write_enable_latch), 8'h01, "latch set");
		pulse_wel(1'b0);
		tx_buf[0] = 8'h99;
		frame(EID_OP_ID_WRITE, 8'h00, 1, 0);
		clk_n(4);
		check(8'(busy), 8'h00, "write without latch");
	endtask : t_power

	task automatic t_write_read();
		set_prot(2'h1, 1'b0);
		check(8'({prot_hi_q, prot_lo_q}), 8'h01, "protect load");
		for (int i = 0; i < 16; i++)
			tx_buf[i] = pat(i);
		pulse_wel(1'b1);
		frame(EID_OP_ID_WRITE, 8'h70, 16, 0);
		check(8'(busy), 8'h01, "write started");
		wait_done(1'b1);
		frame(EID_OP_ID_READ, 8'h00, 16, 0);
		for (int i = 0; i < 16; i++)
			check(rx_buf[i], pat(i), "page read");
	endtask : t_write_read

	task automatic t_busy();
		tx_buf[0] = 8'hc3;
		tx_buf[1] = 8'h3c;
		pulse_wel(1'b1);
		frame(EID_OP_ID_WRITE, 8'h2e, 2, 0);
		watch = 1'b1;
		oe_seen = 1'b0;
		frame(EID_OP_ID_READ, 8'h00, 1, 0);
		frame(EID_OP_LOCK_READ, 8'h80, 1, 0);
		watch = 1'b0;
		check(8'({busy, oe_seen}), 8'h02, "reads while busy");
		wait_done(1'b0);
		// Select rises three bits into the last byte, never past the page end
		frame(EID_OP_ID_READ, 8'h4d, 2, 3);
		check(rx_buf[0], pat(13), "read start");
		check(rx_buf[1], 8'hc3, "read next");
		frame(EID_OP_ID_READ, 8'h0f, 1, 0);
		check(rx_buf[0], 8'h3c, "read last");
		frame(EID_OP_LOCK_READ, 8'hd5, 2, 0);
		check(rx_buf[0], 8'h00, "unlocked");
		check(rx_buf[1], 8'h00, "unlocked again");
	endtask : t_busy

	task automatic t_lock();
		for (int k = 0; k < 4; k++)
		begin
			set_prot((k == 0) ? 2'h3 : 2'h0, 1'b0);
			wp_n = (k != 1);
			pulse_wel(1'b1);
			tx_buf[0] = (k == 2) ? 8'hfd : 8'hc6;
			frame(EID_OP_LOCK, 8'hb5, 1, (k == 3) ? 3 : 0);
			clk_n(4);
			check(8'({busy, locked}), 8'h00, "lock refused");
		end
		wp_n = 1'b1;
		pulse_wel(1'b1);
		frame(EID_OP_LOCK, 8'hb5, 1, 0);
		check(8'(busy), 8'h01, "lock started");
		wait_done(1'b1);
		check(8'(locked), 8'h01, "page locked");
		frame(EID_OP_LOCK_READ, 8'hff, 3, 0);
		for (int i = 0; i < 3; i++)
			check(rx_buf[i], 8'h01, "lock status");
		pulse_wel(1'b1);
		tx_buf[0] = 8'h00;
		frame(EID_OP_ID_WRITE, 8'h00, 1, 0);
		clk_n(4);
		check(8'(busy), 8'h00, "write to locked page");
		frame(EID_OP_ID_READ, 8'h00, 1, 0);
		check(rx_buf[0], pat(0), "page kept");
	endtask : t_lock

	task automatic t_reset();
		set_prot(2'h2, 1'b1);
		pulse_wel(1'b1);
		clk_n(1);
		rst_i = 1'b1;
		clk_n(3);
		rst_i = 1'b0;
		clk_n(1);
		check(8'({locked, prot_hi_q, prot_lo_q, swd_q, write_enable_latch, busy}), 8'h34, "reset");
		clk_n(4);
		frame(EID_OP_LOCK_READ, 8'h80, 1, 0);
		check(rx_buf[0], 8'h01, "after reset");
	endtask : t_reset

	////////////////////////////////////////////////////////////////
	initial
	begin
		rst_i = 1'b1;
		wp_n = 1'b1;
		{wel_set, wel_clr, prot_wr, prot_hi, prot_lo, swd_in, fac_init} = 7'h00;
		{watch, oe_seen} = 2'h0;
		miscompares = 0;
		compares = 0;
		clk_n(10);
		rst_i = 1'b0;
		clk_n(4);
		t_power();
		t_write_read();
		t_busy();
		t_lock();
		t_reset();
		summarize();
	end
endmodule : tb_top
